/* File: shared/gpx_pkg.sv */
// Purpose: Shared constants for the general purpose I/O port block.
// Assumes: One 10 MHz clock; fuse levels are static while the part runs.
// Notes:   Timing figures are kept in their own unit and turned into cycles here.
package gpx_pkg;

	// Port widths.
	localparam int unsigned WIDE_W   = 8;
	localparam int unsigned NARROW_W = 3;

	// Bit positions of the special functions on the narrow port.
	localparam int unsigned RST_BIT     = 0;
	localparam int unsigned OSC_IN_BIT  = 1;
	localparam int unsigned OSC_OUT_BIT = 2;

	// Reset values of the output data flops.
	localparam logic [7:0] WIDE_OUT_RST   = 8'h00;
	localparam logic [2:0] NARROW_OUT_RST = 3'h0;

	// Clock period and the least reset pulse on the reset pin.
	localparam int unsigned CLK_PERIOD_NS    = 100;
	localparam int unsigned RST_MIN_PULSE_NS = 2500;
	// A least time rounds up to whole cycles.
	localparam int unsigned RST_MIN_CYC = (RST_MIN_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned RST_CNT_W   = 8;

	// Reset pin filter states.
	typedef enum logic [1:0] {
		GPX_RP_IDLE  = 2'b00,
		GPX_RP_COUNT = 2'b01,
		GPX_RP_HOLD  = 2'b10
	} gpx_rp_state_e;

endpackage

/* File: core/gpx_port_bits.sv */
// Purpose: One port of general purpose pins: output flops, drivers, pull-ups, input synchroniser.
// Assumes: Control inputs come from logic on ref_clk; pin inputs come from outside.
// Notes:   Output enable and pull-up are gated combinationally so a reset floats the pins at once.
module gpx_port_bits #(
	parameter int unsigned W       = 8,
	parameter logic [W-1:0] OUT_RST = '0
) (
	input  wire logic         ref_clk,
	input  wire logic         rst,
	input  wire logic         clk_en,
	input  wire logic         hiz,
	input  wire logic [W-1:0] claim,
	input  wire logic [W-1:0] out_val,
	input  wire logic [W-1:0] dir,
	input  wire logic [W-1:0] pu_en,
	input  wire logic [W-1:0] pin_i,
	output logic      [W-1:0] pin_o,
	output logic      [W-1:0] pin_oe,
	output logic      [W-1:0] pin_pu,
	output logic      [W-1:0] rd_val
);

	logic [W-1:0] out_q;
	logic [W-1:0] meta_q;
	logic [W-1:0] sync_q;
	wire  [W-1:0] free;

	// Wider ports would need a wider pin model, so they are refused when the design is built.
	if (W < 1 || W > 8) begin : g_bad_width
		$error("gpx_port_bits: width must be 1 to 8");
	end

	// Output data flops and the two-stage input synchroniser.
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			out_q  <= OUT_RST;
			meta_q <= '0;
			sync_q <= '0;
		end else if (clk_en) begin
			out_q  <= out_val;
			meta_q <= pin_i;
			sync_q <= meta_q;
		end
	end

	// A pin is free for general use when no special function owns it and no reset holds.
	assign free   = ~claim & {W{~hiz}};
	assign pin_o  = out_q;
	assign pin_oe = dir & free;
	// Pull-ups only apply to inputs, as on an output they would just fight the driver.
	assign pin_pu = pu_en & ~dir & free;
	assign rd_val = sync_q;

endmodule

/* File: core/gpx_io_ports.sv */
// Purpose: Three wide and one narrow general purpose port with reset pin and oscillator pin options.
// Assumes: Fuse inputs are static; the oscillator amplifier itself lives outside this block.
// Notes:   Pin floating on reset is combinational, so it does not wait for a clock edge.

// Notes on behaviour
// RULE1 - Each wide port has eight two-way pins, each with its own pull-up enable.
// RULE2 - The narrow port has three two-way pins with per-bit pull-ups and special uses.
// RULE3 - Any active reset floats every port pin at once, with or without a clock.
// RULE4 - With the reset-disable fuse programmed, narrow bit zero is an ordinary pin.
// RULE5 - With the fuse unprogrammed, a long enough low on bit zero resets the part.
// RULE6 - The outside reset source holds the pin low at least the least pulse length.
// RULE7 - When the oscillator is selected, narrow bit one feeds the amplifier and clock circuit.
// RULE8 - When the oscillator is selected, narrow bit two carries the amplifier output.
// RULE9 - A pin claimed by reset or oscillator has its general driver and pull-up off.
module gpx_io_ports (
	input  wire logic        ref_clk,
	input  wire logic        rst,
	input  wire logic        clk_en,
	input  wire logic        reset_pin_disable_fuse,
	input  wire logic        osc_pins_select,
	input  wire logic        osc_amp_drive,
	input  wire logic [7:0]  pb_out,
	input  wire logic [7:0]  pb_dir,
	input  wire logic [7:0]  pb_pu_en,
	input  wire logic [7:0]  pb_pin_i,
	output logic      [7:0]  pb_pin_o,
	output logic      [7:0]  pb_pin_oe,
	output logic      [7:0]  pb_pin_pu,
	output logic      [7:0]  pb_rd,
	input  wire logic [7:0]  pc_out,
	input  wire logic [7:0]  pc_dir,
	input  wire logic [7:0]  pc_pu_en,
	input  wire logic [7:0]  pc_pin_i,
	output logic      [7:0]  pc_pin_o,
	output logic      [7:0]  pc_pin_oe,
	output logic      [7:0]  pc_pin_pu,
	output logic      [7:0]  pc_rd,
	input  wire logic [7:0]  pd_out,
	input  wire logic [7:0]  pd_dir,
	input  wire logic [7:0]  pd_pu_en,
	input  wire logic [7:0]  pd_pin_i,
	output logic      [7:0]  pd_pin_o,
	output logic      [7:0]  pd_pin_oe,
	output logic      [7:0]  pd_pin_pu,
	output logic      [7:0]  pd_rd,
	input  wire logic [2:0]  pe_out,
	input  wire logic [2:0]  pe_dir,
	input  wire logic [2:0]  pe_pu_en,
	input  wire logic [2:0]  pe_pin_i,
	output logic      [2:0]  pe_pin_o,
	output logic      [2:0]  pe_pin_oe,
	output logic      [2:0]  pe_pin_pu,
	output logic      [2:0]  pe_rd,
	output logic             osc_amp_input,
	output logic             pin_reset_async,
	output logic             pin_reset_req
);

	localparam logic [gpx_pkg::RST_CNT_W-1:0] RST_LAST =
		gpx_pkg::RST_CNT_W'(gpx_pkg::RST_MIN_CYC - 1);

	wire        hiz;
	wire        rst_pin_used;
	wire [2:0]  pe_claim;
	wire [2:0]  pe_gp_o;
	wire [2:0]  pe_gp_oe;
	wire        rp_low_s;

	gpx_pkg::gpx_rp_state_e        rp_q;
	gpx_pkg::gpx_rp_state_e        rp_d;
	logic [gpx_pkg::RST_CNT_W-1:0] rp_cnt_q;
	logic [gpx_pkg::RST_CNT_W-1:0] rp_cnt_d;
	logic                          rp_req_q;

	// The filter counter is eight bits wide, so a longer pulse figure is refused at build time.
	if (gpx_pkg::RST_MIN_CYC < 1 || gpx_pkg::RST_MIN_CYC > 255) begin : g_bad_pulse
		$error("gpx_io_ports: reset pulse count does not fit the counter");
	end

	// RULE5 pin reset level
	// The raw pin level is used here on purpose: a reset must act with no clock running.
	assign rst_pin_used    = ~reset_pin_disable_fuse;
	assign pin_reset_async = rst_pin_used & ~pe_pin_i[gpx_pkg::RST_BIT];

	// RULE3 float on reset
	// Any reset source forces every pin to high impedance without waiting for an edge.
	assign hiz = rst | pin_reset_async | rp_req_q;

	// RULE9 claim special pins
	// RULE4 fuse frees bit zero
	assign pe_claim[gpx_pkg::RST_BIT]     = rst_pin_used;
	assign pe_claim[gpx_pkg::OSC_IN_BIT]  = osc_pins_select;
	assign pe_claim[gpx_pkg::OSC_OUT_BIT] = osc_pins_select;

	// RULE1 wide port pins
	gpx_port_bits #(.W(gpx_pkg::WIDE_W), .OUT_RST(gpx_pkg::WIDE_OUT_RST)) u_port_b (
		.ref_clk (ref_clk),
		.rst     (rst),
		.clk_en  (clk_en),
		.hiz     (hiz),
		.claim   (8'h00),
		.out_val (pb_out),
		.dir     (pb_dir),
		.pu_en   (pb_pu_en),
		.pin_i   (pb_pin_i),
		.pin_o   (pb_pin_o),
		.pin_oe  (pb_pin_oe),
		.pin_pu  (pb_pin_pu),
		.rd_val  (pb_rd)
	);

	gpx_port_bits #(.W(gpx_pkg::WIDE_W), .OUT_RST(gpx_pkg::WIDE_OUT_RST)) u_port_c (
		.ref_clk (ref_clk),
		.rst     (rst),
		.clk_en  (clk_en),
		.hiz     (hiz),
		.claim   (8'h00),
		.out_val (pc_out),
		.dir     (pc_dir),
		.pu_en   (pc_pu_en),
		.pin_i   (pc_pin_i),
		.pin_o   (pc_pin_o),
		.pin_oe  (pc_pin_oe),
		.pin_pu  (pc_pin_pu),
		.rd_val  (pc_rd)
	);

	gpx_port_bits #(.W(gpx_pkg::WIDE_W), .OUT_RST(gpx_pkg::WIDE_OUT_RST)) u_port_d (
		.ref_clk (ref_clk),
		.rst     (rst),
		.clk_en  (clk_en),
		.hiz     (hiz),
		.claim   (8'h00),
		.out_val (pd_out),
		.dir     (pd_dir),
		.pu_en   (pd_pu_en),
		.pin_i   (pd_pin_i),
		.pin_o   (pd_pin_o),
		.pin_oe  (pd_pin_oe),
		.pin_pu  (pd_pin_pu),
		.rd_val  (pd_rd)
	);

	// RULE2 narrow port pins
	gpx_port_bits #(.W(gpx_pkg::NARROW_W), .OUT_RST(gpx_pkg::NARROW_OUT_RST)) u_port_e (
		.ref_clk (ref_clk),
		.rst     (rst),
		.clk_en  (clk_en),
		.hiz     (hiz),
		.claim   (pe_claim),
		.out_val (pe_out),
		.dir     (pe_dir),
		.pu_en   (pe_pu_en),
		.pin_i   (pe_pin_i),
		.pin_o   (pe_gp_o),
		.pin_oe  (pe_gp_oe),
		.pin_pu  (pe_pin_pu),
		.rd_val  (pe_rd)
	);

	// RULE7 oscillator input path
	// The clock path is analog in nature, so it bypasses the synchroniser.
	assign osc_amp_input = osc_pins_select & pe_pin_i[gpx_pkg::OSC_IN_BIT];

	// RULE8 oscillator output drive
	assign pe_pin_o[gpx_pkg::RST_BIT]     = pe_gp_o[gpx_pkg::RST_BIT];
	assign pe_pin_o[gpx_pkg::OSC_IN_BIT]  = pe_gp_o[gpx_pkg::OSC_IN_BIT];
	assign pe_pin_o[gpx_pkg::OSC_OUT_BIT] = osc_pins_select ? osc_amp_drive : pe_gp_o[gpx_pkg::OSC_OUT_BIT];
	assign pe_pin_oe[gpx_pkg::RST_BIT]    = pe_gp_oe[gpx_pkg::RST_BIT];
	assign pe_pin_oe[gpx_pkg::OSC_IN_BIT] = pe_gp_oe[gpx_pkg::OSC_IN_BIT];
	assign pe_pin_oe[gpx_pkg::OSC_OUT_BIT] = osc_pins_select ? ~hiz : pe_gp_oe[gpx_pkg::OSC_OUT_BIT];

	// RULE5 filtered reset request
	// The synchronised level counts the low time; a pulse shorter than the least length is dropped.
	assign rp_low_s = rst_pin_used & ~pe_rd[gpx_pkg::RST_BIT];

	// Next state of the reset pin filter.
	always_comb begin
		rp_d     = rp_q;
		rp_cnt_d = rp_cnt_q;
		unique case (rp_q)
			gpx_pkg::GPX_RP_IDLE: begin
				rp_cnt_d = '0;
				if (rp_low_s) begin
					rp_d = gpx_pkg::GPX_RP_COUNT;
				end
			end
			gpx_pkg::GPX_RP_COUNT: begin
				if (!rp_low_s) begin
					rp_d = gpx_pkg::GPX_RP_IDLE;
				end else if (rp_cnt_q == RST_LAST) begin
					rp_d = gpx_pkg::GPX_RP_HOLD;
				end else begin
					rp_cnt_d = rp_cnt_q + 1'b1;
				end
			end
			gpx_pkg::GPX_RP_HOLD: begin
				if (!rp_low_s) begin
					rp_d = gpx_pkg::GPX_RP_IDLE;
				end
			end
			default: begin
				rp_d = gpx_pkg::GPX_RP_IDLE;
			end
		endcase
	end

	// Filter state flops; the request is registered so it is glitch free.
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			rp_q     <= gpx_pkg::GPX_RP_IDLE;
			rp_cnt_q <= '0;
			rp_req_q <= 1'b0;
		end else if (clk_en) begin
			rp_q     <= rp_d;
			rp_cnt_q <= rp_cnt_d;
			rp_req_q <= (rp_d == gpx_pkg::GPX_RP_HOLD);
		end
	end

	assign pin_reset_req = rp_req_q;

	// Helper: length of the current synchronised low run, for checking only.
	logic [gpx_pkg::RST_CNT_W-1:0] chk_low_run_q;
	always_ff @(posedge ref_clk) begin
		if (rst || !rp_low_s) begin
			chk_low_run_q <= '0;
		end else if (clk_en && chk_low_run_q != 8'hFF) begin
			chk_low_run_q <= chk_low_run_q + 1'b1;
		end
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	chk_wide_drive_enable: assert property ( // RULE1
		!hiz |-> (pb_pin_oe == pb_dir) && (pc_pin_oe == pc_dir) && (pd_pin_oe == pd_dir))
		else $error("Wide port enable does not follow direction.");

	chk_wide_pullup_sel: assert property ( // RULE1
		!hiz |-> (pb_pin_pu == (pb_pu_en & ~pb_dir)) && (pd_pin_pu == (pd_pu_en & ~pd_dir))
			&& (pc_pin_pu == (pc_pu_en & ~pc_dir)))
		else $error("Wide port pull-up does not follow its enable.");

	chk_narrow_out_data: assert property ( // RULE2
		clk_en && !osc_pins_select ##1 !rst && !osc_pins_select |-> pe_pin_o == $past(pe_out))
		else $error("Narrow port output data not taken from the flop.");

	chk_reset_floats_pins: assert property (@(posedge ref_clk) disable iff (1'b0) // RULE3
		(rst || pin_reset_async) |-> (pb_pin_oe == 8'h00) && (pc_pin_oe == 8'h00)
			&& (pd_pin_oe == 8'h00) && (pe_pin_oe == 3'h0) && (pe_pin_pu == 3'h0))
		else $error("A pin is driven during reset.");

	chk_fuse_gpio_bit: assert property ( // RULE4
		reset_pin_disable_fuse && !hiz |-> pe_pin_oe[0] == pe_dir[0] && !pin_reset_async)
		else $error("Bit zero not ordinary with reset-disable fuse set.");

	chk_pin_reset_time: assert property ( // RULE5
		clk_en && rp_low_s && chk_low_run_q == 8'(gpx_pkg::RST_MIN_CYC + 1) |-> ##[0:2] pin_reset_req)
		else $error("Long low on reset pin gave no reset request.");

	chk_pin_reset_short: assert property ( // RULE5
		$rose(pin_reset_req) |-> $past(chk_low_run_q) >= 8'(gpx_pkg::RST_MIN_CYC - 1))
		else $error("Reset request raised before the least pulse length.");

	// The request is held and the synchronised pin has come back high.
	sequence s_pin_released;
		clk_en && pin_reset_req && !rp_low_s;
	endsequence

	chk_pin_reset_drop: assert property ( // RULE5
		s_pin_released |=> !pin_reset_req)
		else $error("Reset request outlived the low level on the reset pin.");

	chk_osc_in_claim: assert property ( // RULE7
		osc_pins_select |-> !pe_pin_oe[1] && !pe_pin_pu[1] && osc_amp_input == pe_pin_i[1])
		else $error("Oscillator input pin not handed to the amplifier.");

	chk_osc_out_drive: assert property ( // RULE8
		osc_pins_select && !hiz |-> pe_pin_oe[2] && pe_pin_o[2] == osc_amp_drive && !pe_pin_pu[2])
		else $error("Oscillator output pin not driven by the amplifier.");

	chk_claim_disables_gp: assert property ( // RULE9
		!reset_pin_disable_fuse |-> !pe_pin_oe[0] && !pe_pin_pu[0])
		else $error("Reset pin has general driver or pull-up on.");

endmodule

/* File: bench/gpx_board.sv */
// Purpose: Board model for one port: works out each pin level from all parties.
// Assumes: The device driver wins over the outside source, which wins over the pull-up.
// Notes:   A pin that nobody drives and no pull-up holds toggles every cycle, so no stale level is read.
module gpx_board #(
	parameter int unsigned W = 8
) (
	input  wire logic         ref_clk,
	input  wire logic [W-1:0] pin_o,
	input  wire logic [W-1:0] pin_oe,
	input  wire logic [W-1:0] pin_pu,
	input  wire logic [W-1:0] ext_en,
	input  wire logic [W-1:0] ext_val,
	output logic      [W-1:0] pin_i
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [W-1:0] float_q = '0;

	// A floating pin shows a pattern that changes every cycle.
	always @(posedge ref_clk) begin
		float_q <= ~float_q;
	end

	// Resolve each pin from device drive, outside drive and pull-up.
	always_comb begin
		for (int i = 0; i < W; i++) begin
			pin_i[i] = pin_oe[i] ? pin_o[i] : ext_en[i] ? ext_val[i] : pin_pu[i] ? 1'b1 : float_q[i];
		end
	end
endmodule

/* File: bench/gpx_io_ports_test.sv */
// Purpose: Self-checking bench for the general purpose I/O port block.
// Assumes: Inputs change 5 ns after the rising edge; the clock enable drops only in the freeze test.
// Notes:   Drivers queue expected values; a falling-edge monitor compares each when it falls due.
module gpx_io_ports_test;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct {
		int         due;
		int         p;
		int         k;
		logic [7:0] exp;
		string      name;
	} gpx_note_s;
	localparam int LIMIT = 400;
	logic       ref_clk = 1'b0;
	logic       rst     = 1'b1;
	logic       clk_en  = 1'b1;
	logic       fuse    = 1'b1;
	logic       osc_sel = 1'b0;
	logic       osc_drv = 1'b0;
	logic [7:0] dv[4], dd[4], du[4], xe[4], xv[4], pi[4];
	logic [7:0] o[4][4];
	logic [2:0] fl;
	logic [31:0] r;
	int         cyc = 0;
	int         n_mismatch = 0;
	int         check_count = 0;
	int         seed = 32'h0797214b;
	int         qi;
	gpx_note_s  q[$];

	always #50 ref_clk = ~ref_clk;

	gpx_io_ports i_dut (
		.ref_clk(ref_clk), .rst(rst), .clk_en(clk_en), .reset_pin_disable_fuse(fuse),
		.osc_pins_select(osc_sel), .osc_amp_drive(osc_drv),
		.pb_out(dv[0]), .pb_dir(dd[0]), .pb_pu_en(du[0]), .pb_pin_i(pi[0]),
		.pb_pin_o(o[0][0]), .pb_pin_oe(o[0][1]), .pb_pin_pu(o[0][2]), .pb_rd(o[0][3]),
		.pc_out(dv[1]), .pc_dir(dd[1]), .pc_pu_en(du[1]), .pc_pin_i(pi[1]),
		.pc_pin_o(o[1][0]), .pc_pin_oe(o[1][1]), .pc_pin_pu(o[1][2]), .pc_rd(o[1][3]),
		.pd_out(dv[2]), .pd_dir(dd[2]), .pd_pu_en(du[2]), .pd_pin_i(pi[2]),
		.pd_pin_o(o[2][0]), .pd_pin_oe(o[2][1]), .pd_pin_pu(o[2][2]), .pd_rd(o[2][3]),
		.pe_out(dv[3][2:0]), .pe_dir(dd[3][2:0]), .pe_pu_en(du[3][2:0]), .pe_pin_i(pi[3][2:0]),
		.pe_pin_o(o[3][0][2:0]), .pe_pin_oe(o[3][1][2:0]), .pe_pin_pu(o[3][2][2:0]), .pe_rd(o[3][3][2:0]),
		.osc_amp_input(fl[2]), .pin_reset_async(fl[1]), .pin_reset_req(fl[0])
	);

	// One board model per wide port, one for the narrow port.
	for (genvar g = 0; g < 3; g++) begin : g_brd
		gpx_board #(.W(8)) u_brd (.ref_clk(ref_clk), .pin_o(o[g][0]), .pin_oe(o[g][1]),
			.pin_pu(o[g][2]), .ext_en(xe[g]), .ext_val(xv[g]), .pin_i(pi[g]));
	end
	gpx_board #(.W(3)) u_brd_e (.ref_clk(ref_clk), .pin_o(o[3][0][2:0]), .pin_oe(o[3][1][2:0]),
		.pin_pu(o[3][2][2:0]), .ext_en(xe[3][2:0]), .ext_val(xv[3][2:0]), .pin_i(pi[3][2:0]));

	// Port 4 is the flag group, port 5 the OR of every enable and pull-up.
	function automatic logic [7:0] obs(int p, int k);
		logic [7:0] m;
		m = '0;
		if (p == 4)
			return {5'h00, fl};
		if (p == 5) begin
			for (int i = 0; i < 4; i++)
				m |= (o[i][1] | o[i][2]) & (i == 3 ? 8'h07 : 8'hFF);
			return m;
		end
		return p == 3 ? {5'h00, o[3][k][2:0]} : o[p][k];
	endfunction

	task automatic check(logic [7:0] seen, logic [7:0] exp, string name);
		check_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic note(int d, int p, int k, logic [7:0] e, string n);
		q.push_back('{cyc + d, p, k, e, n});
	endtask

	task automatic step(int n);
		repeat (n) @(posedge ref_clk);
		#5;
	endtask

	task automatic done(string s);
		while (q.size() > 0)
			step(1);
		$display("Test %s finished", s);
	endtask

	task automatic close_out();
		$display("Checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// Compare every note that has fallen due, oldest first.
	always @(negedge ref_clk) begin
		qi = 0;
		while (qi < q.size()) begin
			if (q[qi].due <= cyc) begin
				check(obs(q[qi].p, q[qi].k), q[qi].exp, q[qi].name);
				q.delete(qi);
			end else
				qi++;
		end
	end

	// A hang counts as a mismatch and ends the run.
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (cyc == LIMIT) begin
			n_mismatch++;
			close_out();
		end
	end

	initial begin
		logic [7:0] m;
		for (int i = 0; i < 4; i++) begin
			dv[i] = '0;
			{dd[i], du[i]} = '1;
			{xe[i], xv[i]} = '1;
		end
		step(9);
		note(0, 5, 0, 8'h00, "float in reset");
		step(1);
		rst = 1'b0;
		done("reset");
		repeat (4) begin
			for (int p = 0; p < 4; p++) begin
				r = $random(seed);
				dv[p] = r[7:0];
				dd[p] = r[15:8];
				du[p] = r[23:16];
				xe[p] = ~r[15:8];
				xv[p] = r[31:24];
				m = p == 3 ? 8'h07 : 8'hFF;
				note(0, p, 1, r[15:8] & m, "enable");
				note(0, p, 2, r[23:16] & ~r[15:8] & m, "pull-up");
				note(1, p, 0, r[7:0] & m, "pin out");
				note(3, p, 3, ((r[7:0] & r[15:8]) | (r[31:24] & ~r[15:8])) & m, "pin read");
			end
			step(4);
		end
		done("ports");
		{xe[3], xv[3], dd[3], du[3]} = '1;
		fuse = 1'b0;
		note(0, 3, 1, 8'h06, "reset pin enable");
		step(1);
		dd[3] = 8'h00;
		note(0, 3, 2, 8'h06, "reset pin pull-up");
		step(1);
		osc_sel = 1'b1;
		osc_drv = 1'b1;
		dv[3] = 8'h00;
		note(0, 3, 1, 8'h04, "osc enables");
		note(0, 3, 2, 8'h00, "osc pull-ups");
		note(0, 4, 0, 8'h04, "osc input");
		note(1, 3, 0, 8'h04, "osc output");
		step(2);
		osc_drv = 1'b0;
		xv[3] = 8'h05;
		note(0, 4, 0, 8'h00, "osc input low");
		note(0, 3, 0, 8'h00, "osc output low");
		dd[0] = 8'hFF;
		done("osc");
		xv[3] = 8'h00;
		note(0, 4, 0, 8'h02, "reset pin raw");
		note(0, 5, 0, 8'h00, "float on pin reset");
		note(gpx_pkg::RST_MIN_CYC, 4, 0, 8'h02, "reset filter early");
		note(gpx_pkg::RST_MIN_CYC + 4, 4, 0, 8'h03, "reset filter");
		step(gpx_pkg::RST_MIN_CYC + 6);
		xv[3] = 8'hFF;
		note(6, 0, 1, 8'hFF, "drive after reset");
		note(6, 4, 0, 8'h04, "reset filter drop");
		done("reset pin");
		xv[3] = 8'h00;
		step(9);
		note(0, 4, 0, 8'h02, "short pulse");
		step(1);
		xv[3] = 8'hFF;
		note(4, 4, 0, 8'h04, "no reset");
		done("short pulse");
		// A low clock enable must hold the output flops where they were.
		dv[1] = 8'h3C;
		note(1, 1, 0, 8'h3C, "pin out before freeze");
		step(1);
		clk_en = 1'b0;
		dv[1] = 8'hC3;
		note(2, 1, 0, 8'h3C, "pin out frozen");
		step(2);
		clk_en = 1'b1;
		note(1, 1, 0, 8'hC3, "pin out thawed");
		done("freeze");
		rst = 1'b1;
		note(0, 5, 0, 8'h00, "float on reset");
		step(2);
		rst = 1'b0;
		done("mid reset");
		close_out();
	end
endmodule
